// ===== rtl/scl_irq_ctrl.sv
// Purpose: scl phase counts, bus event detection and interrupt status
// Assumes: register port on i_ref_clk; pins sampled through pin_sync
// Notes: lower eight status bits are levels kept by the data path
//
// Operation
// - standard low phase from standard low count
// - fast high phase from fast high count
// - fast low phase from fast low count
// - count reset values 033a, 03d3, 0075, 010e
// - masked status is raw and mask, reset zero
// - reading source clear register clears its bit
// - raw status shows sources unmasked
// - mask bit one lets source interrupt
// - mask bit map, bits 10..8 reset zero
// - standard high phase from standard high count
// - activity sticky until disable, clear read, write-one clear, reset
// - general call set on acked address, sticky
// - start and stop flagged as master or slave
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "scl_irq_consts.svh"
module scl_irq_ctrl (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // two-wire pins
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // data path status levels and clear pulses
    input wire logic [7:0] i_dp_status,
    output logic [7:0] o_dp_clear,
    // interrupt
    output logic o_irq
);
    // ----------------------------------------
    // decode helper
    // ----------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [3:0] ctrl_ff;
    scl_irq_pkg::phase_cnt_type std_high_ff;
    scl_irq_pkg::phase_cnt_type std_low_ff;
    scl_irq_pkg::phase_cnt_type fast_high_ff;
    scl_irq_pkg::phase_cnt_type fast_low_ff;
    scl_irq_pkg::irq_vec_type mask_ff;
    logic raw_gc_ff;
    logic raw_start_ff;
    logic raw_stop_ff;
    logic raw_act_ff;
    logic nxt_raw_gc;
    logic nxt_raw_start;
    logic nxt_raw_stop;
    logic nxt_raw_act;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic irq_ff;
    logic [7:0] dp_clear_ff;
    logic [1:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic scl_prev_ff;
    logic sda_prev_ff;
    scl_irq_pkg::gc_state_type gc_state_ff;
    scl_irq_pkg::gc_state_type nxt_gc_state;
    logic [3:0] bits_ff;
    logic [3:0] nxt_bits;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic ack_ff;
    logic nxt_ack;
    scl_irq_pkg::irq_vec_type raw_stat;
    scl_irq_pkg::irq_vec_type masked_stat;
    logic enabled;
    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic act_evt;
    logic gc_evt;
    logic addr_is_gc;
    logic rd_clr_all;
    logic rd_clr_act;
    logic rd_clr_gc;
    logic rd_clr_start;
    logic rd_clr_stop;
    logic wr_clr;
    logic [11:0] wr_clr_bits;
    logic clr_gc;
    logic clr_start;
    logic clr_stop;
    logic clr_act;

    scl_timer_if tif ();

    // ----------------------------------------
    // pin synchronisers and scl timer
    // ----------------------------------------
    pin_sync #(
        .W(2)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_clk_en(i_clk_en),
        .i_async({i_sda, i_scl}),
        .o_sync(pins_sync)
    );

    scl_phase_timer u_timer (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_clk_en(i_clk_en),
        .tif(tif.tim)
    );

    // timer steering from control and count registers
    assign tif.run = enabled & ctrl_ff[`CTRL_SCL_RUN];
    assign tif.fast = ctrl_ff[`CTRL_FAST];
    assign tif.std_low = std_low_ff;
    assign tif.std_high = std_high_ff;
    assign tif.fast_low = fast_low_ff;
    assign tif.fast_high = fast_high_ff;
    assign tif.scl_seen = scl_s;

    // ----------------------------------------
    // bus condition detection
    // ----------------------------------------
    assign scl_s = pins_sync[0];
    assign sda_s = pins_sync[1];
    assign enabled = ctrl_ff[`CTRL_ENABLE];
    assign scl_rise = scl_s & ~scl_prev_ff;
    assign scl_fall = ~scl_s & scl_prev_ff;
    // sda edge while scl stays high, whoever drives the bus
    assign start_evt = enabled & scl_s & scl_prev_ff & ~sda_s & sda_prev_ff;
    assign stop_evt = enabled & scl_s & scl_prev_ff & sda_s & ~sda_prev_ff;
    assign act_evt = enabled & (~scl_s | ~sda_s | start_evt);
    assign addr_is_gc = ({shift_ff[6:0], sda_s} == 8'h00) & ctrl_ff[`CTRL_GC_ACK];
    // acked general call: our ack sampled on the ninth rising edge
    assign gc_evt = (gc_state_ff == scl_irq_pkg::GC_ACK) & ack_ff & scl_rise;

    // previous synchronised levels for edge finding
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else if (i_clk_en) begin
            scl_prev_ff <= scl_s;
            sda_prev_ff <= sda_s;
        end
    end

    // ----------------------------------------
    // general-call address watcher
    // ----------------------------------------
    always_comb begin
        nxt_gc_state = gc_state_ff;
        nxt_bits = bits_ff;
        nxt_shift = shift_ff;
        nxt_ack = ack_ff;
        unique case (gc_state_ff)
            scl_irq_pkg::GC_IDLE: begin
                nxt_ack = 1'b0;
            end
            scl_irq_pkg::GC_ADDR: begin
                if (scl_rise) begin
                    nxt_shift = {shift_ff[6:0], sda_s};
                    nxt_bits = bits_ff + 4'h1;
                    if (bits_ff == 4'h7) begin
                        nxt_gc_state = addr_is_gc ? scl_irq_pkg::GC_ACK : scl_irq_pkg::GC_DONE;
                    end
                end
            end
            scl_irq_pkg::GC_ACK: begin
                if (scl_fall && !ack_ff) begin
                    nxt_ack = 1'b1;
                end else if (scl_fall && ack_ff) begin
                    nxt_ack = 1'b0;
                    nxt_gc_state = scl_irq_pkg::GC_DONE;
                end
            end
            scl_irq_pkg::GC_DONE: begin
                nxt_ack = 1'b0;
            end
        endcase
        // conditions that restart or end the watch take priority
        if (!enabled || stop_evt) begin
            nxt_gc_state = scl_irq_pkg::GC_IDLE;
            nxt_ack = 1'b0;
        end else if (start_evt) begin
            nxt_gc_state = scl_irq_pkg::GC_ADDR;
            nxt_bits = 4'h0;
            nxt_ack = 1'b0;
        end
    end

    // watcher state
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            gc_state_ff <= scl_irq_pkg::GC_IDLE;
            bits_ff <= 4'h0;
            shift_ff <= 8'hff;
            ack_ff <= 1'b0;
        end else if (i_clk_en) begin
            gc_state_ff <= nxt_gc_state;
            bits_ff <= nxt_bits;
            shift_ff <= nxt_shift;
            ack_ff <= nxt_ack;
        end
    end

    // ----------------------------------------
    // pin drive: open drain, only ever pulls low
    // ----------------------------------------
    assign o_scl = 1'b0;
    assign o_scl_oe = tif.drive_low;
    assign o_sda = 1'b0;
    assign o_sda_oe = ack_ff;

    // ----------------------------------------
    // register access decode
    // ----------------------------------------
    assign rd_clr_all = i_rd & reg_hit(i_addr, `OFF_CLR_ALL);
    assign rd_clr_act = i_rd & reg_hit(i_addr, `OFF_ACTIVITY_CLEAR_REG);
    assign rd_clr_gc = i_rd & reg_hit(i_addr, `OFF_GENERAL_CALL_CLEAR_REG);
    assign rd_clr_start = i_rd & reg_hit(i_addr, `OFF_CLR_START);
    assign rd_clr_stop = i_rd & reg_hit(i_addr, `OFF_CLR_STOP);
    assign wr_clr = i_wr & reg_hit(i_addr, `OFF_CLR_WRITE);
    assign wr_clr_bits = wr_clr ? i_wdata[11:0] : 12'h000;

    // per-source clears: read clear, global read, write-one clear
    assign clr_gc = rd_clr_gc | rd_clr_all | wr_clr_bits[`IRQ_GEN_CALL] | ~enabled;
    assign clr_start = rd_clr_start | rd_clr_all | wr_clr_bits[`IRQ_START];
    assign clr_stop = rd_clr_stop | rd_clr_all | wr_clr_bits[`IRQ_STOP];
    assign clr_act = rd_clr_act | rd_clr_all | wr_clr_bits[`IRQ_ACTIVITY] | ~enabled;

    // ----------------------------------------
    // sticky raw status, set wins over clear
    // ----------------------------------------
    assign nxt_raw_gc = gc_evt | (raw_gc_ff & ~clr_gc);
    assign nxt_raw_start = start_evt | (raw_start_ff & ~clr_start);
    assign nxt_raw_stop = stop_evt | (raw_stop_ff & ~clr_stop);
    assign nxt_raw_act = act_evt | (raw_act_ff & ~clr_act);

    // unmasked view and masked view
    assign raw_stat = {raw_gc_ff, raw_start_ff, raw_stop_ff, raw_act_ff, i_dp_status};
    assign masked_stat = raw_stat & mask_ff;

    // status flops
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            raw_gc_ff <= 1'b0;
            raw_start_ff <= 1'b0;
            raw_stop_ff <= 1'b0;
            raw_act_ff <= 1'b0;
        end else if (i_clk_en) begin
            raw_gc_ff <= nxt_raw_gc;
            raw_start_ff <= nxt_raw_start;
            raw_stop_ff <= nxt_raw_stop;
            raw_act_ff <= nxt_raw_act;
        end
    end

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_ff <= `RST_CTRL;
            std_high_ff <= `RST_STD_HIGH;
            std_low_ff <= `RST_STD_LOW;
            fast_high_ff <= `RST_FAST_HIGH;
            fast_low_ff <= `RST_FAST_LOW;
            mask_ff <= `RST_IRQ_MASK;
        end else if (i_clk_en && i_wr) begin
            if (reg_hit(i_addr, `OFF_CTRL)) begin
                ctrl_ff <= i_wdata[3:0];
            end
            if (reg_hit(i_addr, `OFF_STD_HIGH)) begin
                std_high_ff <= i_wdata[15:0];
            end
            if (reg_hit(i_addr, `OFF_STD_LOW)) begin
                std_low_ff <= i_wdata[15:0];
            end
            if (reg_hit(i_addr, `OFF_FAST_HIGH)) begin
                fast_high_ff <= i_wdata[15:0];
            end
            if (reg_hit(i_addr, `OFF_FAST_LOW)) begin
                fast_low_ff <= i_wdata[15:0];
            end
            if (reg_hit(i_addr, `OFF_IRQ_MASK)) begin
                mask_ff <= i_wdata[11:0];
            end
        end
    end

    // ----------------------------------------
    // read data, valid the cycle after the strobe only
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (i_rd) begin
            unique case (i_addr)
                `OFF_CTRL: nxt_rdata = {28'h0000000, ctrl_ff};
                `OFF_STD_HIGH: nxt_rdata = {16'h0000, std_high_ff};
                `OFF_STD_LOW: nxt_rdata = {16'h0000, std_low_ff};
                `OFF_FAST_HIGH: nxt_rdata = {16'h0000, fast_high_ff};
                `OFF_FAST_LOW: nxt_rdata = {16'h0000, fast_low_ff};
                `OFF_MASKED_STAT: nxt_rdata = {20'h00000, masked_stat};
                `OFF_IRQ_MASK: nxt_rdata = {20'h00000, mask_ff};
                `OFF_RAW_STAT: nxt_rdata = {20'h00000, raw_stat};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // read data, interrupt level and data path clear pulses
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_ff <= 32'h00000000;
            irq_ff <= 1'b0;
            dp_clear_ff <= 8'h00;
        end else if (i_clk_en) begin
            rdata_ff <= nxt_rdata;
            irq_ff <= |masked_stat;
            dp_clear_ff <= wr_clr_bits[7:0] | {8{rd_clr_all}};
        end
    end

    assign o_rdata = rdata_ff;
    assign o_irq = irq_ff;
    assign o_dp_clear = dp_clear_ff;
endmodule : scl_irq_ctrl

// ===== shared/scl_irq_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit register port, one register per aligned word
// Notes: included by bare name
`ifndef SCL_IRQ_CONSTS_SVH
`define SCL_IRQ_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STD_HIGH 8'h04
`define OFF_STD_LOW 8'h08
`define OFF_FAST_HIGH 8'h0c
`define OFF_FAST_LOW 8'h10
`define OFF_MASKED_STAT 8'h14
`define OFF_IRQ_MASK 8'h18
`define OFF_RAW_STAT 8'h1c
`define OFF_CLR_ALL 8'h20
`define OFF_ACTIVITY_CLEAR_REG 8'h24
`define OFF_GENERAL_CALL_CLEAR_REG 8'h28
`define OFF_CLR_START 8'h2c
`define OFF_CLR_STOP 8'h30
`define OFF_CLR_WRITE 8'h34

// ----------------------------------------
// control fields and status bit positions
// ----------------------------------------
`define CTRL_ENABLE 0
`define CTRL_FAST 1
`define CTRL_SCL_RUN 2
`define CTRL_GC_ACK 3
`define IRQ_GEN_CALL 11
`define IRQ_START 10
`define IRQ_STOP 9
`define IRQ_ACTIVITY 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_STD_HIGH 16'h033a
`define RST_STD_LOW 16'h03d3
`define RST_FAST_HIGH 16'h0075
`define RST_FAST_LOW 16'h010e
`define RST_IRQ_MASK 12'h8ff
`define RST_CTRL 4'h0

// ----------------------------------------
// timing: least phase times and smallest safe counts
// ----------------------------------------
`define SYS_CLK_NS 40
`define HIGH_EXTRA_CYC 7
`define STD_LOW_MIN_NS 4700
`define STD_HIGH_MIN_NS 4000
`define FAST_LOW_MIN_NS 1300
`define FAST_HIGH_MIN_NS 600
`define STD_LOW_MIN_CNT (((`STD_LOW_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS) - 1)
`define STD_HIGH_MIN_CNT (((`STD_HIGH_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS) - 8)
`define FAST_LOW_MIN_CNT (((`FAST_LOW_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS) - 1)
`define FAST_HIGH_MIN_CNT (((`FAST_HIGH_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS) - 8)

`endif

// ===== shared/scl_irq_pkg.sv
// Purpose: types shared by the two-wire timing and interrupt block
// Assumes: nothing
// Notes: constants live in scl_irq_consts.svh
package scl_irq_pkg;
    // general-call address watcher states
    typedef enum logic [1:0] {GC_IDLE, GC_ADDR, GC_ACK, GC_DONE} gc_state_type;
    typedef logic [11:0] irq_vec_type;
    typedef logic [15:0] phase_cnt_type;
endpackage : scl_irq_pkg

// ===== shared/scl_timer_if.sv
// Purpose: carries phase counts and speed to the scl timer
// Assumes: all signals on i_ref_clk
// Notes: no clocking block
`timescale 1ns/10ps
interface scl_timer_if;
    logic run;
    logic fast;
    scl_irq_pkg::phase_cnt_type std_low;
    scl_irq_pkg::phase_cnt_type std_high;
    scl_irq_pkg::phase_cnt_type fast_low;
    scl_irq_pkg::phase_cnt_type fast_high;
    logic scl_seen;
    logic drive_low;
    modport ctl (output run, fast, std_low, std_high, fast_low, fast_high, scl_seen, input drive_low);
    modport tim (input run, fast, std_low, std_high, fast_low, fast_high, scl_seen, output drive_low);
endinterface : scl_timer_if

// ===== rtl/pin_sync.sv
// Purpose: two-flop synchronisers for pin inputs
// Assumes: inputs asynchronous to i_ref_clk
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // pins in, synchronised out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // one pair of flops per pin, idle bus level is high
    for (genvar g = 0; g < W; g++) begin : g_bit
        logic meta_ff;
        logic sync_ff;
        always_ff @(posedge i_ref_clk) begin
            if (i_srst) begin
                meta_ff <= 1'b1;
                sync_ff <= 1'b1;
            end else if (i_clk_en) begin
                meta_ff <= i_async[g];
                sync_ff <= meta_ff;
            end
        end
        assign o_sync[g] = sync_ff;
    end
endmodule : pin_sync

// ===== rtl/scl_phase_timer.sv
// Purpose: times scl low and high phases from the programmed counts
// Assumes: counts stable while running
// Notes: high phase waits for scl seen high, so a stretching slave holds it
`timescale 1ns/10ps
`include "scl_irq_consts.svh"
module scl_phase_timer (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // counts and drive
    scl_timer_if.tim tif
);
    logic [16:0] cnt_ff;
    logic low_ff;
    logic [16:0] low_end;
    logic [16:0] high_end;
    logic phase_done;

    // selection by speed: low lasts count+1 cycles, high count+8
    assign low_end = {1'b0, tif.fast ? tif.fast_low : tif.std_low};
    assign high_end = {1'b0, tif.fast ? tif.fast_high : tif.std_high} + 17'(`HIGH_EXTRA_CYC);
    assign phase_done = low_ff ? (cnt_ff >= low_end) : (cnt_ff >= high_end);
    assign tif.drive_low = low_ff;

    // phase counter, high phase counts only while scl is seen high
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_ff <= 17'h00000;
            low_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (!tif.run) begin
                cnt_ff <= 17'h00000;
                low_ff <= 1'b0;
            end else if (phase_done) begin
                cnt_ff <= 17'h00000;
                low_ff <= ~low_ff;
            end else if (low_ff || tif.scl_seen) begin
                cnt_ff <= cnt_ff + 17'h00001;
            end
        end
    end
endmodule : scl_phase_timer

// ===== tb/scl_irq_ctrl_sva.sv
// Purpose: port checks of the scl timing and interrupt block
// Assumes: one clock domain, bound from the bench
// Notes: sees only top ports
`timescale 1ns/10ps
`include "scl_irq_consts.svh"
module scl_irq_ctrl_sva (
    // clock and control
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // pins, clears, interrupt
    input wire logic i_scl,
    input wire logic o_scl_oe,
    input wire logic o_sda_oe,
    input wire logic [7:0] o_dp_clear,
    input wire logic o_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // taken requests
    wire rd_take = i_rd && i_clk_en;
    wire wr_take = i_wr && i_clk_en;
    wire clr_all = rd_take && i_addr == `OFF_CLR_ALL;
    wire clr_wr = wr_take && i_addr == `OFF_CLR_WRITE;
    wire clr_req = clr_all || clr_wr;
    wire stat_rd = rd_take && (i_addr == `OFF_MASKED_STAT || i_addr == `OFF_RAW_STAT || i_addr == `OFF_IRQ_MASK);

    status_width_a: assert property (stat_rd |=> o_rdata[31:12] == 20'h0)
        else $error("status read has upper bits set");
    irq_matches_stat_a: assert property (rd_take && i_addr == `OFF_MASKED_STAT |=> o_irq == (|o_rdata[11:0]))
        else $error("interrupt disagrees with masked status");
    mask_zero_quiet_a: assert property (wr_take && i_addr == `OFF_IRQ_MASK && i_wdata[11:0] == 12'h000 |-> ##2 !o_irq)
        else $error("interrupt with all sources masked");
    global_clear_a: assert property (clr_all |=> o_dp_clear == 8'hff)
        else $error("global clear did not pulse data path clears");
    write_clear_a: assert property (clr_wr |=> o_dp_clear == $past(i_wdata[7:0]))
        else $error("write clear pulse wrong");
    clear_cause_a: assert property (o_dp_clear != 8'h00 |-> $past(clr_req))
        else $error("clear pulse without request");
    high_phase_min_a: assert property ($fell(o_scl_oe) |=> !o_scl_oe [*8])
        else $error("scl high phase too short");
    ack_on_low_a: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
        else $error("ack driven while scl high");
    ack_bounded_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*2] ##[1:20] !o_sda_oe)
        else $error("ack held too long");

    // main scenarios reached
    cover property (o_irq);
    cover property ($rose(o_sda_oe));
    cover property ($fell(o_scl_oe));
endmodule : scl_irq_ctrl_sva

// ===== tb/far_bus_master.sv
// Purpose: another master on the two-wire bus
// Assumes: lines are pulled up outside
// Notes: its clock stands still between frames
`timescale 1ns/10ps
module far_bus_master (
    // open-drain pulls and sensed data line
    output logic o_scl_low,
    output logic o_sda_low,
    input wire logic i_sda
);
    localparam int HALF_NS = 160;
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // start: data falls while clock high
    task automatic frame_start();
        #7;
        o_sda_low = 1'b1;
        #HALF_NS;
        o_scl_low = 1'b1;
        #HALF_NS;
    endtask : frame_start
    // byte msb first, then ninth clock samples the ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low = !b[i];
            #HALF_NS;
            o_scl_low = 1'b0;
            #HALF_NS;
            o_scl_low = 1'b1;
        end
        o_sda_low = 1'b0;
        #HALF_NS;
        o_scl_low = 1'b0;
        #(HALF_NS / 2);
        ack = i_sda;
        #(HALF_NS / 2);
        o_scl_low = 1'b1;
        #HALF_NS;
    endtask : send_byte
    // stop: data rises while clock high, then both released
    task automatic frame_stop();
        o_sda_low = 1'b1;
        #HALF_NS;
        o_scl_low = 1'b0;
        #HALF_NS;
        o_sda_low = 1'b0;
        #HALF_NS;
    endtask : frame_stop
endmodule : far_bus_master

// ===== tb/test_scl_irq_ctrl.sv
// Purpose: self-checking bench of the scl timing and interrupt block
// Assumes: 25 MHz clock, pulled-up bus lines
// Notes: read results are queued and compared by a monitor
`timescale 1ns/10ps
`include "scl_irq_consts.svh"
module test_scl_irq_ctrl;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0, rd = 1'b0;
    logic rd_due = 1'b0;
    logic [7:0] dp_status = 8'h00;
    logic [31:0] rdata;
    logic [7:0] dp_clear;
    logic scl_oe, sda_oe, irq, far_scl_low, far_sda_low, ack, scl_out, sda_out;
    logic [31:0] exp_q[$];
    logic [11:0] m;
    logic [7:0] d;
    int mismatches = 0;
    int checks = 0;
    // pulled-up open-drain lines
    wire scl_line = !(scl_oe && !scl_out || far_scl_low);
    wire sda_line = !(sda_oe && !sda_out || far_sda_low);

    always #20 ref_clk = ~ref_clk;

    scl_irq_ctrl i_dut (.i_ref_clk(ref_clk), .i_srst(srst), .i_clk_en(1'b1), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl_line), .o_scl(scl_out), .o_scl_oe(scl_oe),
        .i_sda(sda_line), .o_sda(sda_out), .o_sda_oe(sda_oe), .i_dp_status(dp_status), .o_dp_clear(dp_clear),
        .o_irq(irq));
    far_bus_master i_far (.o_scl_low(far_scl_low), .o_sda_low(far_sda_low), .i_sda(sda_line));

    // ----------------------------------------
    // bus tasks, compares and verdict
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic bad(input string msg);
        mismatches++;
        $display("BAD %0t %s", $time, msg);
    endtask : bad
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rd_reg
    task automatic cmp_bit(input logic got, input logic e, input string what);
        checks++;
        if (got !== e) bad(what);
    endtask : cmp_bit
    task automatic cmp_int(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) bad($sformatf("phase %0d cycles", got));
    endtask : cmp_int
    // wait for scl drive level, then count it
    task automatic phase_len(input logic lvl, input int lo, input int hi);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while ((scl_oe === lvl) == (k == 0) && n < 5000) begin
                @(negedge ref_clk);
                n++;
            end
            if (n >= 5000) begin
                bad("timeout");
                tally_and_finish();
            end
        end
        n = 0;
        while (scl_oe === lvl && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        cmp_int(n, lo, hi);
    endtask : phase_len
    task automatic reset_values();
        logic [7:0] offs[7] = '{`OFF_STD_HIGH, `OFF_STD_LOW, `OFF_FAST_HIGH, `OFF_FAST_LOW, `OFF_IRQ_MASK,
            `OFF_CTRL, `OFF_MASKED_STAT};
        logic [31:0] vals[7] = '{32'h033a, 32'h03d3, 32'h0075, 32'h010e, 32'h08ff, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) rd_reg(offs[i], vals[i]);
    endtask : reset_values

    // read results compared while they stand
    always @(posedge ref_clk) rd_due <= rd;
    always @(negedge ref_clk) begin
        if (rd_due && exp_q.size() > 0) begin
            checks++;
            if (rdata !== exp_q[0]) bad($sformatf("read %h expected %h", rdata, exp_q[0]));
            void'(exp_q.pop_front());
        end
    end
    initial begin
        #1_000_000;
        bad("run too long");
        tally_and_finish();
    end

    initial begin
        void'($urandom(48087));
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        reset_values();
        rd_reg(8'h3c, 32'h0);
        bus(1'b1, 1'b0, `OFF_MASKED_STAT, 32'hfff);
        rd_reg(`OFF_MASKED_STAT, 32'h0);
        $display("test reset values done");
        // random mask and source levels
        for (int i = 0; i < 6; i++) begin
            m = 12'($urandom);
            d = 8'($urandom);
            bus(1'b1, 1'b0, `OFF_IRQ_MASK, {20'h0, m});
            dp_status <= d;
            rd_reg(`OFF_IRQ_MASK, {20'h0, m});
            rd_reg(`OFF_RAW_STAT, {24'h0, d});
            rd_reg(`OFF_MASKED_STAT, {24'h0, d & m[7:0]});
            @(negedge ref_clk);
            cmp_bit(irq, |(d & m[7:0]), "irq level");
            bus(1'b1, 1'b0, `OFF_CLR_WRITE, {24'h0, d});
            rd_reg(`OFF_CLR_ALL, 32'h0);
        end
        dp_status <= 8'h00;
        bus(1'b1, 1'b0, `OFF_IRQ_MASK, 32'h0);
        $display("test mask done");
        // phase lengths, standard at reset counts, fast at least counts
        bus(1'b1, 1'b0, `OFF_CTRL, 32'h5);
        phase_len(1'b1, 32'h03d3 + 1, 32'h03d3 + 1);
        phase_len(1'b0, 32'h033a + 8, 32'h033a + 12);
        bus(1'b1, 1'b0, `OFF_CTRL, 32'h0);
        bus(1'b1, 1'b0, `OFF_FAST_HIGH, 32'(`FAST_HIGH_MIN_CNT));
        bus(1'b1, 1'b0, `OFF_FAST_LOW, 32'(`FAST_LOW_MIN_CNT));
        bus(1'b1, 1'b0, `OFF_CTRL, 32'h7);
        phase_len(1'b1, `FAST_LOW_MIN_CNT + 1, `FAST_LOW_MIN_CNT + 1);
        phase_len(1'b0, `FAST_HIGH_MIN_CNT + 8, `FAST_HIGH_MIN_CNT + 12);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        reset_values();
        $display("test scl phases done");
        // general call from another master, sticky bits and clears
        bus(1'b1, 1'b0, `OFF_CTRL, 32'h9);
        bus(1'b1, 1'b0, `OFF_IRQ_MASK, 32'hf00);
        i_far.frame_start();
        i_far.send_byte(8'h00, ack);
        cmp_bit(ack, 1'b0, "general call not acked");
        i_far.frame_stop();
        rd_reg(`OFF_RAW_STAT, 32'hf00);
        rd_reg(`OFF_MASKED_STAT, 32'hf00);
        cmp_bit(irq, 1'b1, "irq missing");
        rd_reg(`OFF_GENERAL_CALL_CLEAR_REG, 32'h0);
        rd_reg(`OFF_RAW_STAT, 32'h700);
        rd_reg(`OFF_CLR_START, 32'h0);
        rd_reg(`OFF_CLR_STOP, 32'h0);
        rd_reg(`OFF_RAW_STAT, 32'h100);
        rd_reg(`OFF_ACTIVITY_CLEAR_REG, 32'h0);
        rd_reg(`OFF_RAW_STAT, 32'h0);
        @(negedge ref_clk);
        cmp_bit(irq, 1'b0, "irq stuck");
        $display("test general call done");
        tally_and_finish();
    end
endmodule : test_scl_irq_ctrl

bind scl_irq_ctrl scl_irq_ctrl_sva i_sva (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl),
    .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_dp_clear(o_dp_clear), .o_irq(o_irq));
